// ==== logic/tdps_defs.vh ====
`ifndef TDPS_DEFS_VH
`define TDPS_DEFS_VH
// timing
`define TDPS_CLK_HZ      20000000
`define TDPS_TICK_MS     1
`define TDPS_TICK_CYC    (`TDPS_CLK_HZ / 1000 * `TDPS_TICK_MS)
`define TDPS_STEP_WRAP   26'd20000000
`define TDPS_MS_PER_S    42'd1000
`define TDPS_SEG_MIN_MS  42'd50
`define TDPS_PAUSE_MS    8'd1
`define TDPS_PAUSE_TICKS (`TDPS_PAUSE_MS / `TDPS_TICK_MS)
`define TDPS_OVR_SHIFT   8
`define TDPS_MIN_SPD     24'h000064
// register byte offsets
`define TDPS_A_CTRL      12'h000
`define TDPS_A_PAT       12'h004
`define TDPS_A_SPD1      12'h008
`define TDPS_A_OVR       12'h00c
`define TDPS_A_RAMP      12'h010
`define TDPS_A_TSTART    12'h014
`define TDPS_A_ITC       12'h018
`define TDPS_A_STAT      12'h01c
`define TDPS_A_XPOS      12'h020
`define TDPS_A_YPOS      12'h024
`define TDPS_A_XTGT      12'h028
`define TDPS_A_YTGT      12'h02c
`define TDPS_A_TBL_HI    4'h1
`define TDPS_F_OP        3'd0
`define TDPS_F_SPD       3'd1
`define TDPS_F_X         3'd2
`define TDPS_F_Y         3'd3
`define TDPS_F_CEN       3'd4
// control and pattern fields
`define TDPS_CTRL_XSTART 0
`define TDPS_CTRL_MCLR   2
`define TDPS_PAT_REL     8
`define TDPS_PAT_NONE    3'd0
`define TDPS_PAT_VAR     3'd1
`define TDPS_PAT_LINSTOP 3'd2
`define TDPS_PAT_TABLE   3'd3
`define TDPS_PAT_MULTI   3'd4
// table operation field
`define TDPS_OP_END      3'd0
`define TDPS_OP_MULTI    3'd1
`define TDPS_OP_LINSTOP  3'd2
`define TDPS_OP_CW       3'd3
`define TDPS_OP_CCW      3'd4
`define TDPS_OP_REL      3
`define TDPS_OP_MCODE    4
`define TDPS_OP_MAFTER   5
`define TDPS_CLS_NONE    2'd0
`define TDPS_CLS_MULTI   2'd1
`define TDPS_CLS_INTERP  2'd2
// reset values
`define TDPS_RST_OVR     16'h0100
`define TDPS_RST_RAMP    16'h03e8
`define TDPS_RST_ITC     16'h0064
`endif

// ==== logic/tdps_seq.v ====
// Overview of operation
// - speed sign flip: stop, then reverse at once
// - multi-speed runs only from table entries
// - start clears completion, runs from start entry
// - multi-speed steps entries until end entry
// - stop at last target, then assert completion
// - next entry prepared during current one
// - short or fast segment forces temporary stop
// - after-mode code holds until host clears
// - other operation type ends multi-speed run
// - speed times override; change gated
// - long-axis speed is X speed or entry speed times override
// - absolute from zero, relative from current
// - direction from compare or from sign
// - interrupt-stop line starts from X only
// - interrupt before target stops early, completes
// - consecutive interpolation entries chain continuously
// - centre arc CW or CCW to target
// - centre always relative to start point
// - equal start and target: full circle
// - too short arc pauses, then continues, only if it ends in a stop
// - zero speed stops but stays variable mode
`timescale 1ns/1ps
`default_nettype none
`include "tdps_defs.vh"

module tdps_seq #(
  parameter TICK_CYC = `TDPS_TICK_CYC
) (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire        firstInterruptInput,
  input  wire        spdChgDisable,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  output reg         xStep_q,
  output reg         xDir_q,
  output reg         yStep_q,
  output reg         yDir_q,
  output reg         posDone_q,
  output reg         mCodeOn_q,
  output reg         busy_q
);
  localparam S_IDLE = 3'd0, S_VAR = 3'd1, S_SEG = 3'd2, S_RUN = 3'd3, S_PAUSE = 3'd4, S_MWAIT = 3'd5;
  integer i;

  //////////////////////////////////////////////////////////////////////////////
  reg  [2:0]  xPat_q, yPat_q;
  reg         relDirect_q, startErr_q, intPrev_q;
  reg  [31:0] spd1_q, xTgt_q, yTgt_q, xPos_q, yPos_q, tickCnt_q;
  reg  [15:0] ovr_q, ramp_q, itc_q;
  reg  [2:0]  tblStart_q;
  reg  [7:0]  tOp_q  [0:7];
  reg  [23:0] tSpd_q [0:7];
  reg  [31:0] tX_q   [0:7];
  reg  [31:0] tY_q   [0:7];
  reg  [31:0] tCen_q [0:7];
  reg  [2:0]  state_q, idx_q, kind_q;
  reg  [1:0]  prevCls_q;
  reg         direct_q, varDir_q, brake_q, stopEnd_q, pauseAfter_q, mAfter_q;
  reg         majX_q, negX_q, negY_q, ccw_q, armed_q;
  reg  [23:0] runSpd_q, curSpd_q, tgtSpd;
  reg  [25:0] acc_q;
  reg  [31:0] rampSteps_q, rem_q, majAbs_q, minAbs_q, err_q, cenX_q, cenY_q, tgtX_q, tgtY_q;
  reg  signed [43:0] r2_q;
  reg  [7:0]  pauseCnt_q;
  reg  [31:0] rdData;
  reg         rdErr;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire        setup    = psel & ~penable;
  wire        wrDone   = psel & penable & pready & pwrite;
  wire        tblHit   = (paddr[11:8] == `TDPS_A_TBL_HI) && (paddr[1:0] == 2'b00) && (paddr[4:2] <= `TDPS_F_CEN);
  wire [2:0]  tEnt     = paddr[7:5];
  wire [2:0]  tFld     = paddr[4:2];
  wire        startX   = wrDone && (paddr == `TDPS_A_CTRL) && pwdata[`TDPS_CTRL_XSTART];
  wire        mClr     = wrDone && (paddr == `TDPS_A_CTRL) && pwdata[`TDPS_CTRL_MCLR];
  wire        spdWr    = wrDone && (paddr == `TDPS_A_SPD1);
  wire [31:0] spdWrMag = pwdata[31] ? (32'h0 - pwdata) : pwdata;
  wire        tick     = (tickCnt_q == TICK_CYC - 1);

  always @* begin
    rdData = 32'h0;
    rdErr  = 1'b0;
    if (tblHit) begin
      if (tFld == `TDPS_F_OP) rdData = {24'h0, tOp_q[tEnt]};
      else if (tFld == `TDPS_F_SPD) rdData = {8'h0, tSpd_q[tEnt]};
      else if (tFld == `TDPS_F_X) rdData = tX_q[tEnt];
      else if (tFld == `TDPS_F_Y) rdData = tY_q[tEnt];
      else rdData = tCen_q[tEnt];
    end else if (paddr == `TDPS_A_CTRL) rdData = 32'h0;
    else if (paddr == `TDPS_A_PAT) rdData = {23'h0, relDirect_q, 1'b0, yPat_q, 1'b0, xPat_q};
    else if (paddr == `TDPS_A_SPD1) rdData = spd1_q;
    else if (paddr == `TDPS_A_OVR) rdData = {16'h0, ovr_q};
    else if (paddr == `TDPS_A_RAMP) rdData = {16'h0, ramp_q};
    else if (paddr == `TDPS_A_TSTART) rdData = {29'h0, tblStart_q};
    else if (paddr == `TDPS_A_ITC) rdData = {16'h0, itc_q};
    else if (paddr == `TDPS_A_STAT)
      rdData = {21'h0, idx_q, 1'b0, state_q, startErr_q, mCodeOn_q, busy_q, posDone_q};
    else if (paddr == `TDPS_A_XPOS) rdData = xPos_q;
    else if (paddr == `TDPS_A_YPOS) rdData = yPos_q;
    else if (paddr == `TDPS_A_XTGT) rdData = xTgt_q;
    else if (paddr == `TDPS_A_YTGT) rdData = yTgt_q;
    else rdErr = 1'b1;
  end

  // config and table; ready one cycle after setup
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pready      <= 1'b0;
      prdata      <= 32'h0;
      pslverr     <= 1'b0;
      xPat_q      <= `TDPS_PAT_NONE;
      yPat_q      <= `TDPS_PAT_NONE;
      relDirect_q <= 1'b0;
      spd1_q      <= 32'h0;
      xTgt_q      <= 32'h0;
      yTgt_q      <= 32'h0;
      ovr_q       <= `TDPS_RST_OVR;
      ramp_q      <= `TDPS_RST_RAMP;
      itc_q       <= `TDPS_RST_ITC;
      tblStart_q  <= 3'h0;
      for (i = 0; i < 8; i = i + 1) begin
        tOp_q[i]  <= 8'h0;
        tSpd_q[i] <= 24'h0;
        tX_q[i]   <= 32'h0;
        tY_q[i]   <= 32'h0;
        tCen_q[i] <= 32'h0;
      end
    end else begin
      pready <= setup;
      prdata  <= setup ? rdData : 32'h0;
      pslverr <= setup & rdErr;
      if (wrDone && !pslverr) begin
        if (tblHit) begin
          if (tFld == `TDPS_F_OP) tOp_q[tEnt] <= pwdata[7:0];
          else if (tFld == `TDPS_F_SPD) tSpd_q[tEnt] <= pwdata[23:0];
          else if (tFld == `TDPS_F_X) tX_q[tEnt] <= pwdata;
          else if (tFld == `TDPS_F_Y) tY_q[tEnt] <= pwdata;
          else tCen_q[tEnt] <= pwdata;
        end else if (paddr == `TDPS_A_PAT) begin
          xPat_q      <= pwdata[2:0];
          yPat_q      <= pwdata[6:4];
          relDirect_q <= pwdata[`TDPS_PAT_REL];
        end else if (paddr == `TDPS_A_SPD1) spd1_q <= pwdata;
        else if (paddr == `TDPS_A_OVR) ovr_q <= pwdata[15:0];
        else if (paddr == `TDPS_A_RAMP) ramp_q <= pwdata[15:0];
        else if (paddr == `TDPS_A_TSTART) tblStart_q <= pwdata[2:0];
        else if (paddr == `TDPS_A_ITC) itc_q <= pwdata[15:0];
        else if (paddr == `TDPS_A_XTGT) xTgt_q <= pwdata;
        else if (paddr == `TDPS_A_YTGT) yTgt_q <= pwdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // speed: base times override, 8 fractional override bits
  wire [39:0] prodRun = {16'h0, runSpd_q} * {24'h0, ovr_q};
  wire [23:0] effRun  = prodRun[31:8];
  wire [31:0] spd1Mag = spd1_q[31] ? (32'h0 - spd1_q) : spd1_q;
  wire        varRev  = (curSpd_q != 24'h0) && (spd1_q[31] != varDir_q);
  wire        varStop = (spd1_q == 32'h0) || varRev || (xPat_q != `TDPS_PAT_VAR);
  wire        isArc   = (kind_q == `TDPS_OP_CW) || (kind_q == `TDPS_OP_CCW);
  wire        brakeEnd = stopEnd_q && !isArc && (rem_q <= rampSteps_q);
  wire        decel   = curSpd_q > tgtSpd;

  always @* begin
    tgtSpd = 24'h0;
    if (state_q == S_VAR) tgtSpd = varStop ? 24'h0 : effRun;
    else if (state_q == S_RUN && !brake_q)
      tgtSpd = (brakeEnd || effRun < `TDPS_MIN_SPD) ? `TDPS_MIN_SPD : effRun;
  end

  //////////////////////////////////////////////////////////////////////////////
  // arc stepping about the centre, picking the move that keeps closest to r^2
  wire [31:0] rxw  = xPos_q - cenX_q;
  wire [31:0] ryw  = yPos_q - cenY_q;
  wire signed [20:0] rx   = rxw[20:0];
  wire signed [20:0] ry   = ryw[20:0];
  wire signed [20:0] tgDx = ccw_q ? -ry : ry;
  wire signed [20:0] tgDy = ccw_q ? rx : -rx;
  wire signed [20:0] dx1  = tgDx[20] ? -21'sd1 : 21'sd1;
  wire signed [20:0] dy1  = tgDy[20] ? -21'sd1 : 21'sd1;
  wire [20:0] absTx = tgDx[20] ? -tgDx : tgDx;
  wire [20:0] absTy = tgDy[20] ? -tgDy : tgDy;
  wire        primX = absTx >= absTy;
  wire signed [20:0] aX = primX ? rx + dx1 : rx;
  wire signed [20:0] aY = primX ? ry : ry + dy1;
  wire signed [20:0] bX = rx + dx1;
  wire signed [20:0] bY = ry + dy1;
  wire signed [43:0] fA = aX * aX + aY * aY - r2_q;
  wire signed [43:0] fB = bX * bX + bY * bY - r2_q;
  wire [43:0] absFA = fA[43] ? -fA : fA;
  wire [43:0] absFB = fB[43] ? -fB : fB;
  wire        useB  = absFB < absFA;
  wire [31:0] dxT   = xPos_q - tgtX_q;
  wire [31:0] dyT   = yPos_q - tgtY_q;
  wire        nearT = (dxT == 32'h0 || dxT == 32'h1 || dxT == 32'hffffffff) &&
                      (dyT == 32'h0 || dyT == 32'h1 || dyT == 32'hffffffff);

  //////////////////////////////////////////////////////////////////////////////
  // step generation
  wire        segEnd  = isArc ? (armed_q && nearT) : (rem_q == 32'h0);
  wire        moving  = (state_q == S_VAR || (state_q == S_RUN && !segEnd)) && (curSpd_q != 24'h0);
  wire [25:0] accSum  = acc_q + {2'b00, curSpd_q};
  wire        stepEv  = moving && (accSum >= `TDPS_STEP_WRAP);
  wire [32:0] errSum  = {1'b0, err_q} + {1'b0, minAbs_q};
  wire        minMove = errSum >= {1'b0, majAbs_q};
  wire        moveX   = (state_q == S_VAR) ? 1'b1 : isArc ? (primX | useB) : (majX_q | minMove);
  wire        moveY   = (state_q == S_VAR) ? 1'b0 : isArc ? (~primX | useB) : (~majX_q | minMove);
  wire        stepNegX = (state_q == S_VAR) ? varDir_q : isArc ? tgDx[20] : negX_q;
  wire        stepNegY = isArc ? tgDy[20] : negY_q;

  //////////////////////////////////////////////////////////////////////////////
  // current entry and prefetched next entry
  wire [2:0]  idxN   = idx_q + 3'd1;
  wire [7:0]  eOp    = direct_q ? {4'h0, relDirect_q, `TDPS_OP_LINSTOP} : tOp_q[idx_q];
  wire [2:0]  eKind  = eOp[2:0];
  wire        eRel   = eOp[`TDPS_OP_REL];
  wire [23:0] eSpd   = direct_q ? spd1Mag[23:0] : tSpd_q[idx_q];
  wire [31:0] eX     = direct_q ? xTgt_q : tX_q[idx_q];
  wire [31:0] eY     = direct_q ? yTgt_q : tY_q[idx_q];
  wire [31:0] eCen   = tCen_q[idx_q];
  wire        eMulti = eKind == `TDPS_OP_MULTI;
  wire        eArc   = (eKind == `TDPS_OP_CW) || (eKind == `TDPS_OP_CCW);
  wire [1:0]  eCls   = eMulti ? `TDPS_CLS_MULTI : (eArc || eKind == `TDPS_OP_LINSTOP) ? `TDPS_CLS_INTERP : `TDPS_CLS_NONE;
  wire [31:0] dX     = eRel ? eX : eX - xPos_q;
  wire [31:0] dY     = eMulti ? 32'h0 : (eRel ? eY : eY - yPos_q);
  wire [31:0] aDX    = dX[31] ? 32'h0 - dX : dX;
  wire [31:0] aDY    = dY[31] ? 32'h0 - dY : dY;
  wire [31:0] endX   = xPos_q + dX;
  wire [31:0] endY   = yPos_q + dY;
  wire signed [15:0] cI = eCen[15:0];
  wire signed [15:0] cJ = eCen[31:16];
  wire [7:0]  nOp    = tOp_q[idxN];
  wire [2:0]  nKind  = nOp[2:0];
  wire [1:0]  nCls   = (nKind == `TDPS_OP_MULTI) ? `TDPS_CLS_MULTI :
                       (nKind == `TDPS_OP_LINSTOP || nKind == `TDPS_OP_CW || nKind == `TDPS_OP_CCW) ?
                       `TDPS_CLS_INTERP : `TDPS_CLS_NONE;
  wire [31:0] nDX    = nOp[`TDPS_OP_REL] ? tX_q[idxN] : tX_q[idxN] - endX;
  wire [31:0] naD    = nDX[31] ? 32'h0 - nDX : nDX;
  wire [39:0] prodN  = {16'h0, tSpd_q[idxN]} * {24'h0, ovr_q};
  wire [39:0] prodE  = {16'h0, eSpd} * {24'h0, ovr_q};
  wire [41:0] nDistMs = naD * `TDPS_MS_PER_S;
  wire [41:0] nSpdMin = prodN[31:8] * `TDPS_SEG_MIN_MS;
  wire        shortN = (naD < rampSteps_q) || (nDistMs <= nSpdMin);
  wire        dirDiff = (naD != 32'h0) && (nDX[31] != dX[31]);
  wire        sameN  = !direct_q && (nCls == eCls) && (nCls != `TDPS_CLS_NONE);
  wire [31:0] chord  = aDX + aDY;
  wire [41:0] chordMs = chord * `TDPS_MS_PER_S;
  wire [41:0] arcLim  = prodE[31:8] * itc_q;
  wire        arcShort = eArc && (chord != 32'h0) && (chordMs < arcLim);
  wire        eAfter = eOp[`TDPS_OP_MCODE] && eOp[`TDPS_OP_MAFTER];
  wire        ending = (eKind == `TDPS_OP_END) || (eCls == `TDPS_CLS_NONE) ||
                       ((prevCls_q != `TDPS_CLS_NONE) && (eCls != prevCls_q));

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tickCnt_q <= 32'h0;
      state_q <= S_IDLE;
      idx_q <= 3'h0;
      kind_q <= `TDPS_OP_END;
      prevCls_q <= `TDPS_CLS_NONE;
      {direct_q, varDir_q, brake_q, stopEnd_q, pauseAfter_q, mAfter_q} <= 6'h0;
      {majX_q, negX_q, negY_q, ccw_q, armed_q, startErr_q, intPrev_q} <= 7'h0;
      {runSpd_q, curSpd_q} <= 48'h0;
      acc_q <= 26'h0;
      {rampSteps_q, rem_q, majAbs_q, minAbs_q, err_q} <= 160'h0;
      {cenX_q, cenY_q, tgtX_q, tgtY_q, xPos_q, yPos_q} <= 192'h0;
      r2_q <= 44'sh0;
      pauseCnt_q <= 8'h0;
      {xStep_q, xDir_q, yStep_q, yDir_q, posDone_q, mCodeOn_q, busy_q} <= 7'h0;
    end else begin
      tickCnt_q <= tick ? 32'h0 : tickCnt_q + 32'h1;
      xStep_q <= 1'b0;
      yStep_q <= 1'b0;
      intPrev_q <= firstInterruptInput;
      busy_q <= (state_q != S_IDLE);
      if (tick) begin
        if (curSpd_q < tgtSpd)
          curSpd_q <= (tgtSpd - curSpd_q > {8'h0, ramp_q}) ? curSpd_q + {8'h0, ramp_q} : tgtSpd;
        else if (decel)
          curSpd_q <= (curSpd_q - tgtSpd > {8'h0, ramp_q}) ? curSpd_q - {8'h0, ramp_q} : tgtSpd;
      end
      acc_q <= !moving ? 26'h0 : stepEv ? accSum - `TDPS_STEP_WRAP : accSum;
      if (stepEv) begin
        xStep_q <= moveX;
        yStep_q <= moveY;
        if (moveX) begin
          xPos_q <= stepNegX ? xPos_q - 32'h1 : xPos_q + 32'h1;
          xDir_q <= ~stepNegX;
        end
        if (moveY) begin
          yPos_q <= stepNegY ? yPos_q - 32'h1 : yPos_q + 32'h1;
          yDir_q <= ~stepNegY;
        end
        // ramp distance mirrors the braking distance for a symmetric ramp
        if (curSpd_q < tgtSpd) rampSteps_q <= rampSteps_q + 32'h1;
        else if (decel && rampSteps_q != 32'h0) rampSteps_q <= rampSteps_q - 32'h1;
      end
      if (spdWr && state_q == S_RUN && !decel && !brake_q && !brakeEnd && !spdChgDisable)
        runSpd_q <= spdWrMag[23:0];
      if (mClr) mCodeOn_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (startX) begin
            startErr_q <= 1'b0;
            if (xPat_q == `TDPS_PAT_VAR) begin
              state_q <= S_VAR;
              posDone_q <= 1'b0;
              varDir_q <= spd1_q[31];
            end else if (xPat_q == `TDPS_PAT_LINSTOP) begin
              state_q <= S_SEG;
              direct_q <= 1'b1;
              prevCls_q <= `TDPS_CLS_NONE;
              posDone_q <= 1'b0;
            end else if (xPat_q == `TDPS_PAT_TABLE) begin
              state_q <= S_SEG;
              direct_q <= 1'b0;
              idx_q <= tblStart_q;
              prevCls_q <= `TDPS_CLS_NONE;
              posDone_q <= 1'b0;
            end else
              startErr_q <= 1'b1;
          end
        end
        S_VAR: begin
          runSpd_q <= spd1Mag[23:0];
          if (curSpd_q == 24'h0) begin
            if (xPat_q != `TDPS_PAT_VAR) state_q <= S_IDLE;
            else if (spd1_q != 32'h0) varDir_q <= spd1_q[31];
            rampSteps_q <= 32'h0;
          end
        end
        S_SEG: begin
          if (ending) begin
            state_q <= S_IDLE;
            posDone_q <= 1'b1;
            curSpd_q <= 24'h0;
          end else begin
            state_q <= S_RUN;
            prevCls_q <= eCls;
            kind_q <= eKind;
            runSpd_q <= eSpd;
            brake_q <= 1'b0;
            majX_q <= aDX >= aDY;
            rem_q <= eArc ? 32'h1 : ((aDX >= aDY) ? aDX : aDY);
            majAbs_q <= (aDX >= aDY) ? aDX : aDY;
            minAbs_q <= (aDX >= aDY) ? aDY : aDX;
            err_q <= 32'h0;
            negX_q <= dX[31];
            negY_q <= dY[31];
            ccw_q <= eKind == `TDPS_OP_CCW;
            cenX_q <= xPos_q + {{16{cI[15]}}, cI};
            cenY_q <= yPos_q + {{16{cJ[15]}}, cJ};
            r2_q <= cI * cI + cJ * cJ;
            tgtX_q <= endX;
            tgtY_q <= endY;
            armed_q <= 1'b0;
            mAfter_q <= eAfter;
            stopEnd_q <= direct_q || !sameN || eAfter || (eMulti && (shortN || dirDiff));
            pauseAfter_q <= eMulti ? shortN : arcShort;
            if (eOp[`TDPS_OP_MCODE] && !eAfter) mCodeOn_q <= 1'b1;
          end
        end
        S_RUN: begin
          if (stepEv) begin
            if (isArc) begin
              if (!nearT) armed_q <= 1'b1;
            end else begin
              rem_q <= rem_q - 32'h1;
              err_q <= minMove ? errSum[31:0] - majAbs_q : errSum[31:0];
            end
          end
          if (brake_q) begin
            if (curSpd_q == 24'h0) begin
              state_q <= S_IDLE;
              posDone_q <= 1'b1;
            end
          end else if (kind_q == `TDPS_OP_LINSTOP && firstInterruptInput && !intPrev_q) begin
            brake_q <= 1'b1;
          end else if (segEnd) begin
            idx_q <= idxN;
            if (direct_q) begin
              state_q <= S_IDLE;
              posDone_q <= 1'b1;
              curSpd_q <= 24'h0;
            end else if (stopEnd_q) begin
              curSpd_q <= 24'h0;
              rampSteps_q <= 32'h0;
              pauseCnt_q <= 8'h0;
              if (mAfter_q) begin
                state_q <= S_MWAIT;
                mCodeOn_q <= 1'b1;
              end else state_q <= pauseAfter_q ? S_PAUSE : S_SEG;
            end else
              state_q <= S_SEG;
          end
        end
        S_PAUSE: begin
          if (tick) pauseCnt_q <= pauseCnt_q + 8'h1;
          if (pauseCnt_q >= `TDPS_PAUSE_TICKS) state_q <= S_SEG;
        end
        S_MWAIT: begin
          if (!mCodeOn_q) state_q <= pauseAfter_q ? S_PAUSE : S_SEG;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== dv/tdps_seq_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module tdps_seq_checker (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        xStep_q,
  input wire logic        xDir_q,
  input wire logic        yStep_q,
  input wire logic        posDone_q,
  input wire logic        mCodeOn_q
);
  wire ctrlWr  = psel && penable && pready && pwrite && paddr == 12'h000;
  wire startWr = ctrlWr && pwdata[0];
  wire codeClr = ctrlWr && pwdata[2];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  property p_rdy_setup; psel && !penable |=> pready; endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("no ready");
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
  property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("bad error");
  property p_dir_step; $changed(xDir_q) |-> xStep_q; endproperty
  a_dir_step: assert property (p_dir_step) else $error("dir without step");
  property p_quiet_done; posDone_q && $past(posDone_q) |-> !xStep_q && !yStep_q; endproperty
  a_quiet_done: assert property (p_quiet_done) else $error("step while complete");
  property p_done_hold; posDone_q && !startWr && !$past(startWr) |=> posDone_q; endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped");
  property p_start_clr; startWr && posDone_q |-> ##[1:2] !posDone_q; endproperty
  a_start_clr: assert property (p_start_clr) else $error("done not cleared");
  property p_code_hold; mCodeOn_q && !codeClr && !$past(codeClr) |=> mCodeOn_q; endproperty
  a_code_hold: assert property (p_code_hold) else $error("code dropped");
endmodule
bind tdps_seq tdps_seq_checker chk_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .xStep_q(xStep_q), .xDir_q(xDir_q), .yStep_q(yStep_q), .posDone_q(posDone_q), .mCodeOn_q(mCodeOn_q));
`default_nettype wire

// ==== dv/tdps_axis_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tdps_axis_model (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic               step,
  input  wire logic               dir,
  output var  logic signed [31:0] pos,
  output var  logic        [31:0] cnt
);
  // no lag, so checks stay exact
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pos <= 32'h0;
      cnt <= 32'h0;
    end else if (step) begin
      pos <= dir ? pos + 32'sh1 : pos - 32'sh1;
      cnt <= cnt + 32'h1;
    end
  end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [31:0] ALL = 32'hffffffff;
  localparam logic [31:0] SPD = 32'h000186a0;
  logic               clk_sys = 1'b0;
  logic               sys_rst = 1'b1;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic        [11:0] paddr = 12'h000;
  logic        [31:0] pwdata = 32'h0;
  logic               firstInterruptInput = 1'b0;
  logic               spdChgDisable = 1'b0;
  logic               pready, pslverr, xStep_q, xDir_q, yStep_q, yDir_q, posDone_q, mCodeOn_q, busy_q, lastErr;
  logic        [31:0] prdata, xCnt, rnd, c0;
  logic signed [31:0] xPos, yPos;
  logic        [63:0] e;
  logic        [63:0] expQ[$];
  int                 mismatches = 0;
  int                 tests_run = 0;
  always #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  tdps_seq #(.TICK_CYC(20)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .firstInterruptInput(firstInterruptInput),
    .spdChgDisable(spdChgDisable), .pready(pready), .prdata(prdata), .pslverr(pslverr), .xStep_q(xStep_q),
    .xDir_q(xDir_q), .yStep_q(yStep_q), .yDir_q(yDir_q), .posDone_q(posDone_q), .mCodeOn_q(mCodeOn_q),
    .busy_q(busy_q));
  tdps_axis_model xm (.clk_sys(clk_sys), .sys_rst(sys_rst), .step(xStep_q), .dir(xDir_q), .pos(xPos), .cnt(xCnt));
  tdps_axis_model ym (.clk_sys(clk_sys), .sys_rst(sys_rst), .step(yStep_q), .dir(yDir_q), .pos(yPos), .cnt());
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic hang;
    mismatches++;
    print_verdict;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) hang;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
    expQ.push_back({m, x});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic ent(input logic [2:0] i, input logic [31:0] op, input logic [31:0] x, input logic [31:0] y,
                     input logic [31:0] cen);
    wr({4'h1, i, 5'h00}, op);
    wr({4'h1, i, 5'h04}, SPD);
    wr({4'h1, i, 5'h08}, x);
    wr({4'h1, i, 5'h0c}, y);
    wr({4'h1, i, 5'h10}, cen);
  endtask
  task automatic run(input logic [31:0] pat, input logic [2:0] first);
    wr(12'h014, {29'h0, first});
    wr(12'h004, pat);
    wr(12'h000, 32'h3);
  endtask
  task automatic wt(input logic code);
    int n = 0;
    @(posedge clk_sys);
    while ((code ? mCodeOn_q : posDone_q) !== 1'b1 && n < 40000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 40000) hang;
  endtask
  // read data taken at the closing edge
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
      e = expQ.pop_front();
      chk(prdata & e[63:32], e[31:0] & e[63:32]);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hb388f460));
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(12'h00c, 32'h100, ALL);
    rd(12'h010, 32'h3e8, ALL);
    rd(12'h018, 32'h64, ALL);
    rd(12'hffc, 32'h0, ALL);
    chk(lastErr, 32'h1);
    run(32'h4, 3'h0);
    rd(12'h01c, 32'h8, 32'h8);
    $display("reset test done");
    rnd = $urandom % 15 + 1;
    wr(12'h008, SPD);
    wr(12'h010, SPD);
    wr(12'h028, 32'h14);
    wr(12'h02c, rnd);
    run(32'h12, 3'h0);
    wt(1'b0);
    rd(12'h020, 32'h14, ALL);
    rd(12'h024, rnd, ALL);
    wr(12'h028, 32'hffffffd8);
    wr(12'h02c, 32'h0);
    run(32'h102, 3'h0);
    repeat (2000) @(posedge clk_sys);
    firstInterruptInput <= 1'b1;
    wt(1'b0);
    chk(xPos < 20 && xPos > -20, 32'h1);
    $display("line test done");
    firstInterruptInput <= 1'b0;
    ent(3'h0, 32'h1, 32'h32, 32'h0, 32'h0);
    ent(3'h1, 32'h9, 32'ha, 32'h0, 32'h0);
    ent(3'h2, 32'h0, 32'h0, 32'h0, 32'h0);
    run(32'h3, 3'h0);
    wt(1'b0);
    rd(12'h020, 32'h3c, ALL);
    c0 = xCnt;
    ent(3'h3, 32'h3, 32'h3c, rnd, 32'h0000fffc);
    ent(3'h4, 32'h0, 32'h0, 32'h0, 32'h0);
    run(32'h3, 3'h3);
    wt(1'b0);
    rd(12'h020, 32'h3c, ALL);
    chk(xCnt - c0 > 8, 32'h1);
    $display("table test done");
    ent(3'h5, 32'h31, 32'h46, 32'h0, 32'h0);
    ent(3'h6, 32'h1, 32'h50, 32'h0, 32'h0);
    ent(3'h7, 32'h0, 32'h0, 32'h0, 32'h0);
    run(32'h3, 3'h5);
    wt(1'b1);
    repeat (500) @(posedge clk_sys);
    rd(12'h020, 32'h46, ALL);
    rd(12'h01c, 32'h4, 32'h5);
    wr(12'h000, 32'h4);
    wt(1'b0);
    rd(12'h020, 32'h50, ALL);
    $display("code test done");
    run(32'h1, 3'h0);
    repeat (1000) @(posedge clk_sys);
    wr(12'h008, 32'h0);
    repeat (1000) @(posedge clk_sys);
    c0 = xCnt;
    repeat (1000) @(posedge clk_sys);
    chk(xCnt, c0);
    rd(12'h01c, 32'h2, 32'h3);
    wr(12'h008, 32'hfffe7960);
    repeat (4000) @(posedge clk_sys);
    chk(xPos < 80, 32'h1);
    wr(12'h004, 32'h0);
    repeat (400) @(posedge clk_sys);
    rd(12'h01c, 32'h0, 32'h3);
    $display("speed test done");
    print_verdict;
  end
endmodule
`default_nettype wire
